// ### verification/dpr_link_properties.sv
// concurrent checks on the controller-to-device link
`timescale 1ns/100ps
`include "dpr_defs.svh"
module dpr_link_properties (
    input wire logic clk,
    input wire logic rst,
    input wire logic ck,
    input wire logic cke,
    input wire logic rst_n,
    input wire logic odt,
    input wire dpr_pkg::dpr_cmd_t cmd,
    input wire logic [2:0] ba,
    input wire logic [12:0] addr
);
    localparam int CK_CLK = 2 * `DPR_CK_HALF;
    localparam int TPD_CLK = `DPR_TPD_CK * CK_CLK;
    localparam int TCKE_CLK = `DPR_TCKE_CK * CK_CLK;
    localparam int TXPDLL_CLK = `DPR_TXPDLL_CK * CK_CLK;
    localparam int PD_MAX_CLK = (9 * `DPR_TREFI_NS) / `DPR_CLK_NS;
    logic cke_q_r;
    logic pd_r;
    logic xit_r;
    logic [15:0] run_r;
    // cycles at the present cke level; saturates so a long idle never wraps
    always_ff @(posedge clk) begin
        if (rst) begin
            cke_q_r <= 1'b0;
            run_r <= 16'h0000;
            pd_r <= 1'b0;
            xit_r <= 1'b0;
        end else begin
            cke_q_r <= cke;
            if (cke != cke_q_r) begin
                run_r <= 16'h0001;
            end else if (run_r != 16'hFFFF) begin
                run_r <= run_r + 16'h0001;
            end
            if (!rst_n) begin
                pd_r <= 1'b0;
                xit_r <= 1'b0;
            end else if (cke_q_r && !cke) begin
                pd_r <= 1'b1;
            end else if (!cke_q_r && cke) begin
                pd_r <= 1'b0;
                xit_r <= pd_r;
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    pd_entry_nop_a: assert property ($fell(cke) |-> cmd == dpr_pkg::CMD_NOP)
        else $error("cke dropped without a nop");
    pd_exit_nop_a: assert property ($rose(cke) |-> cmd == dpr_pkg::CMD_NOP)
        else $error("cke raised without a nop");
    ck_running_a: assert property ($rose(ck) |-> ck [*4] ##1 !ck [*4] ##1 ck)
        else $error("link clock not running at clk/8");
    pd_min_time_a: assert property ($rose(cke) && pd_r |-> run_r >= TPD_CLK)
        else $error("power-down left too early");
    pd_max_time_a: assert property (pd_r && !cke |-> run_r <= PD_MAX_CLK)
        else $error("power-down held too long");
    cke_high_time_a: assert property ($fell(cke) && rst_n |->
        run_r >= (xit_r ? TXPDLL_CLK : TCKE_CLK))
        else $error("cke high stretch too short");
    exit_cmd_gap_a: assert property ($rose(cke) && pd_r |-> (cmd == dpr_pkg::CMD_NOP) [*8]
        ##1 (cmd == dpr_pkg::CMD_NOP) [*8] ##1 (cmd == dpr_pkg::CMD_NOP) [*8])
        else $error("command issued inside exit latency");
    reset_width_a: assert property ($fell(rst_n) |-> !rst_n [*8] ##1 !rst_n [*5])
        else $error("device reset pulse too short");
    reset_release_a: assert property ($rose(rst_n) |-> !cke)
        else $error("reset released with cke high");
    link_edge_a: assert property ($changed(cke) || $changed(cmd) |-> $fell(ck))
        else $error("link changed off the ck falling edge");
endmodule // dpr_link_properties

// ### verification/dpr_tb_top.sv
// bench: both link ends joined, driven over apb, device state observed
`timescale 1ns/100ps
`include "dpr_defs.svh"
module ddr3_powerdown_reset_odt_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, err;
    logic in_reset_r, apd_r, ppd_r, dll_on_r, odt_async_r, rtt_nom_r, rtt_wr_r, termination_strobe_pair_term_r;
    logic [2:0] wr_rec_r;
    logic [12:0] ref_count_r;
    logic [31:0] rd;
    int errors = 0;
    int n_tests = 0;
    int cyc = 0;
    dpr_link_if u_dpr_link_if ();
    dpr_ctl u_dpr_ctl (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .lnk(u_dpr_link_if));
    dpr_dev u_dpr_dev (.clk(clk), .rst(rst), .lnk(u_dpr_link_if), .in_reset_r(in_reset_r),
        .apd_r(apd_r), .ppd_r(ppd_r), .dll_on_r(dll_on_r), .odt_async_r(odt_async_r),
        .rtt_nom_r(rtt_nom_r), .rtt_wr_r(rtt_wr_r), .termination_strobe_pair_term_r(termination_strobe_pair_term_r),
        .wr_rec_r(wr_rec_r), .ref_count_r(ref_count_r));
    dpr_link_properties u_dpr_link_properties (.clk(clk), .rst(rst), .ck(u_dpr_link_if.ck),
        .cke(u_dpr_link_if.cke), .rst_n(u_dpr_link_if.rst_n), .odt(u_dpr_link_if.odt),
        .cmd(u_dpr_link_if.cmd), .ba(u_dpr_link_if.ba), .addr(u_dpr_link_if.addr));
    // free-running clock; the link clock comes from the controller divider
    initial begin
        forever #4 clk = ~clk;
    end
    // hang guard: the whole sequence needs well under this many cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            errors = errors + 1;
            summarize();
        end
    end
    task automatic summarize();
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [31:0] mk(input dpr_pkg::dpr_cmd_t c, input logic [2:0] b,
        input logic [12:0] a);
        mk = {3'h0, a, 9'h000, b, 1'b0, c};
    endfunction
    // queue a command, then poll status until the controller has sent it
    task automatic issue(input dpr_pkg::dpr_cmd_t c, input logic [2:0] b, input logic [12:0] a);
        apb(1'b1, `DPR_REG_CMD, mk(c, b, a));
        for (int i = 0; i < 40; i++) begin
            apb(1'b0, `DPR_REG_STATUS, 32'h00000000);
            if (rd[`DPR_ST_PEND] === 1'b0) break;
        end
    endtask
    task automatic wait_on(ref logic s, input logic v);
        for (int i = 0; i < 10000 && s !== v; i++) @(posedge clk);
    endtask
    task automatic t_init();
        wait_on(in_reset_r, 1'b1);
        chk("in_reset", 32'h1, in_reset_r);
        chk("rtt_nom in reset", 32'h0, rtt_nom_r);
        wait_on(in_reset_r, 1'b0);
        apb(1'b0, `DPR_REG_STATUS, 32'h00000000);
        chk("init needed", 32'h1, rd[`DPR_ST_INIT]);
        issue(dpr_pkg::CMD_MRS, 3'h0, 13'h0000);
        issue(dpr_pkg::CMD_MRS, 3'h1, 13'h0804);
        chk("wr_rec", 32'(3'(`DPR_TWR_CK)), wr_rec_r);
        chk("init cleared", 32'h0, rd[`DPR_ST_INIT]);
    endtask
    task automatic t_odt();
        apb(1'b1, `DPR_REG_CTRL, 32'h00000002);
        wait_on(rtt_nom_r, 1'b1);
        chk("rtt_nom on", 32'h1, rtt_nom_r);
        chk("strobe pair term", 32'h1, termination_strobe_pair_term_r);
        chk("rtt_wr idle", 32'h0, rtt_wr_r);
        apb(1'b1, `DPR_REG_CTRL, 32'h00000000);
        wait_on(rtt_nom_r, 1'b0);
        chk("rtt_nom off", 32'h0, rtt_nom_r);
    endtask
    // precharge power-down; fast selects dll kept on
    task automatic t_ppd(input logic fast);
        apb(1'b1, `DPR_REG_CTRL, 32'h00000001);
        wait_on(ppd_r, 1'b1);
        chk("ppd", 32'h1, ppd_r);
        chk("apd", 32'h0, apd_r);
        chk("dll in pd", 32'(fast), dll_on_r);
        chk("odt async", 32'(!fast), odt_async_r);
        apb(1'b1, `DPR_REG_CTRL, 32'h00000000);
        wait_on(ppd_r, 1'b0);
        chk("ppd exit", 32'h0, ppd_r);
        apb(1'b0, `DPR_REG_STATUS, 32'h00000000);
        chk("slow exit", 32'(!fast), rd[`DPR_ST_SLOW]);
        wait_on(odt_async_r, 1'b0);
        chk("dll relocked", 32'h1, dll_on_r);
    endtask
    task automatic t_apd();
        issue(dpr_pkg::CMD_ACT, 3'h2, 13'h0010);
        apb(1'b1, `DPR_REG_CTRL, 32'h00000001);
        wait_on(apd_r, 1'b1);
        chk("apd", 32'h1, apd_r);
        chk("ppd", 32'h0, ppd_r);
        chk("dll in apd", 32'h1, dll_on_r);
        wait_on(apd_r, 1'b0);
        chk("pd max exit", 32'h0, apd_r);
        apb(1'b1, `DPR_REG_CTRL, 32'h00000000);
        issue(dpr_pkg::CMD_PRE, 3'h0, 13'h0400);
        issue(dpr_pkg::CMD_REF, 3'h0, 13'h0000);
        apb(1'b0, 8'h0C, 32'h00000000);
        chk("unmapped err", 32'h1, err);
        apb(1'b0, `DPR_REG_CMD, 32'h00000000);
        chk("last cmd", mk(dpr_pkg::CMD_REF, 3'h0, 13'h0000), rd);
    endtask
    task automatic t_rst_pd();
        apb(1'b1, `DPR_REG_CTRL, 32'h00000001);
        wait_on(ppd_r, 1'b1);
        chk("refresh count", 32'h1, ref_count_r);
        apb(1'b1, `DPR_REG_CTRL, 32'h00000004);
        wait_on(in_reset_r, 1'b1);
        chk("pd left", 32'h0, ppd_r);
        chk("refresh cleared", 32'h0, ref_count_r);
        wait_on(in_reset_r, 1'b0);
        apb(1'b0, `DPR_REG_STATUS, 32'h00000000);
        chk("reinit needed", 32'h1, rd[`DPR_ST_INIT]);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_init();
        t_odt();
        t_ppd(1'b0);
        issue(dpr_pkg::CMD_MRS, 3'h1, 13'h1004);
        t_ppd(1'b1);
        t_apd();
        t_rst_pd();
        summarize();
    end
endmodule // ddr3_powerdown_reset_odt_tb_top

// ### verilog/dpr_ctl.sv
// memory controller end: APB registers, ck divider, power-down and reset sequencing
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "dpr_defs.svh"
module dpr_ctl (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    dpr_link_if.ctl lnk
);
    dpr_pkg::dpr_ctl_t q;
    dpr_pkg::dpr_ctl_t n;
    logic fall;
    logic acc;
    logic dll_wait;

    // tWR in clocks to the MR0 code; short values round up to the least setting
    function automatic logic [2:0] wr_code(input logic [4:0] c);
        if (c <= 5'h5) begin
            return 3'h1;
        end
        if (c <= 5'h8) begin
            return 3'(c - 5'h4);
        end
        return 3'((c + 5'h1) >> 1);
    endfunction

    function automatic logic [11:0] dec(input logic [11:0] v);
        return (v == 12'h000) ? 12'h000 : v - 12'h001;
    endfunction

    always_comb begin
        n = q;
        fall = (q.div == 3'(`DPR_CK_HALF - 1)) && q.lnk.ck;
        acc = psel && penable && q.pready;
        dll_wait = q.slow && q.txpdll != 12'h000;
        // apb: one wait state, answer registered
        n.pready = psel && penable && !q.pready;
        n.perr = 1'b0;
        if (n.pready) begin
            n.perr = !(paddr == `DPR_REG_CTRL || paddr == `DPR_REG_CMD
                || paddr == `DPR_REG_STATUS);
            n.prdata = 32'h00000000;
            if (paddr == `DPR_REG_CTRL) begin
                n.prdata[`DPR_CTRL_PD] = q.pd_req;
                n.prdata[`DPR_CTRL_ODT] = q.odt_req;
            end else if (paddr == `DPR_REG_CMD) begin
                n.prdata[2:0] = q.pcmd;
                n.prdata[`DPR_CMD_BA_LO +: 3] = q.pba;
                n.prdata[`DPR_CMD_ADDR_LO +: 13] = q.paddr;
            end else if (paddr == `DPR_REG_STATUS) begin
                n.prdata[`DPR_ST_PD] = q.st == dpr_pkg::C_PD;
                n.prdata[`DPR_ST_RESET] = q.st == dpr_pkg::C_RESET;
                n.prdata[`DPR_ST_INIT] = q.init_needed;
                n.prdata[`DPR_ST_SLOW] = q.slow;
                n.prdata[`DPR_ST_PEND] = q.pend;
                n.prdata[`DPR_ST_DLLWAIT] = dll_wait;
            end
        end
        // software writes take effect on the completing edge only
        if (acc && pwrite && paddr == `DPR_REG_CTRL) begin
            n.pd_req = pwdata[`DPR_CTRL_PD];
            n.odt_req = pwdata[`DPR_CTRL_ODT];
        end
        if (acc && pwrite && paddr == `DPR_REG_CMD && !q.pend) begin
            // a second command while one waits is dropped; status shows pend
            n.pend = 1'b1;
            n.pcmd = dpr_pkg::dpr_cmd_t'(pwdata[2:0]);
            n.pba = pwdata[`DPR_CMD_BA_LO +: 3];
            n.paddr = pwdata[`DPR_CMD_ADDR_LO +: 13];
        end
        // ck divider; link signals change on the falling ck edge only, except on a software reset
        if (q.div == 3'(`DPR_CK_HALF - 1)) begin
            n.div = 3'h0;
            n.lnk.ck = !q.lnk.ck;
        end else begin
            n.div = q.div + 3'h1;
        end
        if (fall) begin
            n.lnk.cmd = dpr_pkg::CMD_NOP;
            n.tpd = dec(q.tpd);
            n.tcke = dec(q.tcke);
            n.txp = dec(q.txp);
            n.txpdll = dec(q.txpdll);
            n.trfc = dec(q.trfc);
            n.op = dec(q.op);
            n.pdlen = dec(q.pdlen);
        end
        unique case (q.st)
            dpr_pkg::C_RESET: begin
                // reset held for whole clk cycles, CKE already low at release
                n.lnk.rstn = 1'b0;
                n.lnk.cke = 1'b0;
                n.lnk.odt = 1'b0;
                if (q.rcnt != 5'(`DPR_RESET_CLK)) begin
                    n.rcnt = q.rcnt + 5'h01;
                end else if (fall) begin
                    n.lnk.rstn = 1'b1;
                    n.st = dpr_pkg::C_IDLE;
                    n.init_needed = 1'b1;
                end
            end
            dpr_pkg::C_IDLE: if (fall) begin
                n.lnk.odt = q.odt_req && !dll_wait;
                if (!q.lnk.cke) begin
                    // after reset release cke rises with a nop; commands wait tXP
                    n.lnk.cke = 1'b1;
                    n.tcke = 12'(`DPR_TCKE_CK);
                    n.txp = 12'(`DPR_TXP_CK);
                end else if (q.pd_req && !q.pend && q.op == 12'h000 && q.txpdll == 12'h000
                    && q.tcke == 12'h000 && q.trfc == 12'h000) begin
                    // entry only with NOP and no read, write or mode set running
                    n.lnk.cke = 1'b0;
                    n.st = dpr_pkg::C_PD;
                    n.tpd = 12'(`DPR_TPD_CK);
                    // one less: the exit fall itself adds a ck to the stretch
                    n.pdlen = 12'(`DPR_PD_MAX_CK - 1);
                    n.slow = 1'b0;
                    n.txpdll = 12'h000;
                end else if (q.pend && q.txp == 12'h000
                    && !(q.pcmd == dpr_pkg::CMD_RD && dll_wait)) begin
                    // tXP before any command, tXPDLL before read after slow exit
                    n.pend = 1'b0;
                    n.lnk.cmd = q.pcmd;
                    n.lnk.ba = q.pba;
                    n.lnk.addr = q.paddr;
                    unique case (q.pcmd)
                        dpr_pkg::CMD_ACT: n.banks[q.pba] = 1'b1;
                        dpr_pkg::CMD_PRE: begin
                            if (q.paddr[`DPR_ADDR_ALLBANK]) begin
                                n.banks = 8'h00;
                            end else begin
                                n.banks[q.pba] = 1'b0;
                            end
                        end
                        dpr_pkg::CMD_REF: n.trfc = 12'(`DPR_TRFC_CK);
                        dpr_pkg::CMD_RD: n.op = 12'(`DPR_OP_CK);
                        dpr_pkg::CMD_WR: n.op = 12'(`DPR_OP_CK + `DPR_TWR_CK);
                        dpr_pkg::CMD_WRAP: begin
                            n.op = 12'(`DPR_OP_CK + `DPR_TWR_CK);
                            n.banks[q.pba] = 1'b0;
                        end
                        dpr_pkg::CMD_MRS: begin
                            n.op = 12'(`DPR_OP_CK);
                            n.init_needed = 1'b0;
                            if (q.pba == 3'h0) begin
                                n.lnk.addr[`DPR_MR0_WR_LO +: 3] =
                                    wr_code(5'(`DPR_TWR_CK));
                            end else if (q.pba == 3'h1) begin
                                n.ppd = q.paddr[`DPR_MR1_PPD];
                            end
                        end
                        dpr_pkg::CMD_NOP: ;
                    endcase
                end
            end
            dpr_pkg::C_PD: if (fall) begin
                n.lnk.cke = 1'b0;
                if (q.tpd == 12'h000 && (!q.pd_req || q.pdlen == 12'h000)) begin
                    // exit with NOP; tXPDLL runs from this edge
                    n.lnk.cke = 1'b1;
                    n.st = dpr_pkg::C_IDLE;
                    n.tcke = 12'(`DPR_TCKE_CK);
                    n.txp = 12'(`DPR_TXP_CK);
                    n.txpdll = 12'(`DPR_TXPDLL_CK);
                    n.slow = q.banks == 8'h00 && !q.ppd;
                end
            end
            default: n.st = dpr_pkg::C_RESET;
        endcase
        // software reset wins over everything but a command issued on the same fall, also in power-down
        if (acc && pwrite && paddr == `DPR_REG_CTRL && pwdata[`DPR_CTRL_RST]) begin
            n.st = dpr_pkg::C_RESET;
            n.rcnt = 5'h00;
            n.pend = 1'b0;
            n.banks = 8'h00;
            n.lnk.rstn = 1'b0;
            n.lnk.cke = 1'b0;
            n.lnk.odt = 1'b0;
        end
    end

    // single state register; reset value puts the link in reset with CKE low
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.perr;
    assign lnk.ck = q.lnk.ck;
    assign lnk.cke = q.lnk.cke;
    assign lnk.rst_n = q.lnk.rstn;
    assign lnk.odt = q.lnk.odt;
    assign lnk.cmd = q.lnk.cmd;
    assign lnk.ba = q.lnk.ba;
    assign lnk.addr = q.lnk.addr;
endmodule // dpr_ctl

// ### verilog/dpr_defs.svh
// timing counts, register offsets and field positions of the power-down/reset link
`ifndef DPR_DEFS_SVH
`define DPR_DEFS_SVH
`define DPR_CLK_NS 8
`define DPR_CK_HALF 4
`define DPR_CK_NS (`DPR_CLK_NS * 2 * `DPR_CK_HALF)
`define DPR_RESET_NS 100
`define DPR_RESET_CLK ((`DPR_RESET_NS + `DPR_CLK_NS - 1) / `DPR_CLK_NS)
`define DPR_TPD_CK 3
`define DPR_TCKE_CK 3
`define DPR_TXP_CK 3
`define DPR_TXPDLL_NS 24
`define DPR_TXPDLL_MIN_CK 10
`define DPR_TXPDLL_NSCK ((`DPR_TXPDLL_NS + `DPR_CK_NS - 1) / `DPR_CK_NS)
`define DPR_TXPDLL_CK \
    ((`DPR_TXPDLL_NSCK > `DPR_TXPDLL_MIN_CK) ? `DPR_TXPDLL_NSCK : `DPR_TXPDLL_MIN_CK)
`define DPR_TRFC_NS 110
`define DPR_TRFC_CK ((`DPR_TRFC_NS + `DPR_CK_NS - 1) / `DPR_CK_NS)
`define DPR_TREFI_NS 7800
`define DPR_PD_MAX_CK ((9 * `DPR_TREFI_NS) / `DPR_CK_NS)
`define DPR_TWR_NS 15
`define DPR_TWR_CK ((`DPR_TWR_NS + `DPR_CK_NS - 1) / `DPR_CK_NS)
`define DPR_OP_CK 16
`define DPR_BURST_CK 4
`define DPR_REG_CTRL 8'h00
`define DPR_REG_CMD 8'h04
`define DPR_REG_STATUS 8'h08
`define DPR_CTRL_PD 0
`define DPR_CTRL_ODT 1
`define DPR_CTRL_RST 2
`define DPR_CMD_BA_LO 4
`define DPR_CMD_ADDR_LO 16
`define DPR_ST_PD 0
`define DPR_ST_RESET 1
`define DPR_ST_INIT 2
`define DPR_ST_SLOW 3
`define DPR_ST_PEND 4
`define DPR_ST_DLLWAIT 5
`define DPR_MR1_DLLDIS 0
`define DPR_MR1_TERMINATION_STROBE_PAIR 11
`define DPR_MR1_PPD 12
`define DPR_MR0_WR_LO 9
`define DPR_MR2_RTTWR_LO 9
`define DPR_ADDR_ALLBANK 10
`endif

// ### verilog/dpr_dev.sv
// memory device end: power-down tracking, reset and termination gating
`timescale 1ns/100ps
`include "dpr_defs.svh"
module dpr_dev (
    input wire logic clk,
    input wire logic rst,
    dpr_link_if.dev lnk,
    output logic in_reset_r,
    output logic apd_r,
    output logic ppd_r,
    output logic dll_on_r,
    output logic odt_async_r,
    output logic rtt_nom_r,
    output logic rtt_wr_r,
    output logic termination_strobe_pair_term_r,
    output logic [2:0] wr_rec_r,
    output logic [12:0] ref_count_r
);
    dpr_pkg::dpr_dev_t q;
    dpr_pkg::dpr_dev_t n;
    logic rise;
    logic nom_en;
    logic [7:0] open_after;

    // write recovery code to clock count, as the controller programmed it
    function automatic logic [4:0] wr_cycles(input logic [2:0] c);
        if (c == 3'h0) begin
            return 5'h10;
        end
        if (c <= 3'h4) begin
            return {2'h0, c} + 5'h4;
        end
        return {1'b0, c, 1'b0};
    endfunction

    // next state; pins pass two flops before use since ck is only sampled here
    always_comb begin
        n = q;
        n.s1 = '{lnk.ck, lnk.cke, lnk.rst_n, lnk.odt, lnk.cmd, lnk.ba, lnk.addr};
        n.s2 = q.s1;
        n.ckp = q.s2.ck;
        rise = q.s2.ck && !q.ckp;
        nom_en = |{q.mr1[9], q.mr1[6], q.mr1[2]};
        // a pending auto precharge counts as closed: it finishes during entry
        open_after = q.banks & ~((q.wrapc != 5'h0) ? (8'h01 << q.wrap_ba) : 8'h00);
        if (!q.s2.rstn) begin
            // reset acts in any state, no clock edge needed
            n.st = dpr_pkg::D_RESET;
            n.banks = 8'h00;
            n.refcnt = 13'h0000;
            n.mr0_wr = 3'h0;
            n.mr1 = 13'h0000;
            n.rtt_wr = 2'h0;
            n.burst = 3'h0;
            n.wrapc = 5'h00;
            n.dllsync = 4'h0;
        end else if (rise) begin
            if (q.burst != 3'h0) begin
                n.burst = q.burst - 3'h1;
            end
            if (q.dllsync != 4'h0) begin
                n.dllsync = q.dllsync - 4'h1;
            end
            if (q.wrapc != 5'h0) begin
                n.wrapc = q.wrapc - 5'h1;
                if (q.wrapc == 5'h1) begin
                    n.banks[q.wrap_ba] = 1'b0;
                end
            end
            unique case (q.st)
                dpr_pkg::D_RESET: begin
                    // cke low after release is init, not a power-down entry
                    if (q.s2.cke) begin
                        n.st = dpr_pkg::D_IDLE;
                    end
                end
                dpr_pkg::D_IDLE: begin
                    if (!q.s2.cke && q.s2.cmd == dpr_pkg::CMD_NOP) begin
                        // entry mode from banks left open and the exit bit
                        if (open_after != 8'h00) begin
                            n.st = dpr_pkg::D_APD;
                        end else if (q.mr1[`DPR_MR1_PPD]) begin
                            n.st = dpr_pkg::D_PPD_FAST;
                        end else begin
                            n.st = dpr_pkg::D_PPD_SLOW;
                        end
                    end else if (q.s2.cke) begin
                        unique case (q.s2.cmd)
                            dpr_pkg::CMD_ACT: n.banks[q.s2.ba] = 1'b1;
                            dpr_pkg::CMD_PRE: begin
                                if (q.s2.addr[`DPR_ADDR_ALLBANK]) begin
                                    n.banks = 8'h00;
                                end else begin
                                    n.banks[q.s2.ba] = 1'b0;
                                end
                            end
                            dpr_pkg::CMD_REF: n.refcnt = q.refcnt + 13'h0001;
                            dpr_pkg::CMD_WR: n.burst = 3'(`DPR_BURST_CK);
                            dpr_pkg::CMD_WRAP: begin
                                n.burst = 3'(`DPR_BURST_CK);
                                n.wrapc = 5'(`DPR_BURST_CK) + wr_cycles(q.mr0_wr);
                                n.wrap_ba = q.s2.ba;
                            end
                            dpr_pkg::CMD_MRS: begin
                                if (q.s2.ba == 3'h0) begin
                                    n.mr0_wr = q.s2.addr[`DPR_MR0_WR_LO +: 3];
                                end else if (q.s2.ba == 3'h1) begin
                                    n.mr1 = q.s2.addr;
                                end else if (q.s2.ba == 3'h2) begin
                                    n.rtt_wr = q.s2.addr[`DPR_MR2_RTTWR_LO +: 2];
                                end
                            end
                            dpr_pkg::CMD_NOP, dpr_pkg::CMD_RD: ;
                        endcase
                    end
                end
                dpr_pkg::D_APD, dpr_pkg::D_PPD_FAST: begin
                    if (q.s2.cke) begin
                        n.st = dpr_pkg::D_IDLE;
                    end
                end
                dpr_pkg::D_PPD_SLOW: begin
                    if (q.s2.cke) begin
                        n.st = dpr_pkg::D_IDLE;
                        n.dllsync = 4'(`DPR_TXPDLL_CK);
                    end
                end
                default: n.st = dpr_pkg::D_RESET;
            endcase
        end
        // status and termination outputs, one clock behind state
        n.in_reset = q.st == dpr_pkg::D_RESET;
        n.apd = q.st == dpr_pkg::D_APD;
        n.ppd = q.st == dpr_pkg::D_PPD_FAST || q.st == dpr_pkg::D_PPD_SLOW;
        n.dll_on = !n.in_reset && !q.mr1[`DPR_MR1_DLLDIS] && q.st != dpr_pkg::D_PPD_SLOW;
        n.odt_async = q.st == dpr_pkg::D_PPD_SLOW || q.dllsync != 4'h0;
        // off in reset and dll-disable; ignored when both registers disable it
        n.rtt_wr_on = !n.in_reset && !q.mr1[`DPR_MR1_DLLDIS] && q.burst != 3'h0
            && q.rtt_wr != 2'h0 && q.s2.odt;
        n.rtt_nom = !n.in_reset && !q.mr1[`DPR_MR1_DLLDIS] && nom_en && q.s2.odt
            && !n.rtt_wr_on;
        n.termination_strobe_pair_term = (n.rtt_nom || n.rtt_wr_on) && q.mr1[`DPR_MR1_TERMINATION_STROBE_PAIR];
    end

    // single state register
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign in_reset_r = q.in_reset;
    assign apd_r = q.apd;
    assign ppd_r = q.ppd;
    assign dll_on_r = q.dll_on;
    assign odt_async_r = q.odt_async;
    assign rtt_nom_r = q.rtt_nom;
    assign rtt_wr_r = q.rtt_wr_on;
    assign termination_strobe_pair_term_r = q.termination_strobe_pair_term;
    assign wr_rec_r = q.mr0_wr;
    assign ref_count_r = q.refcnt;
endmodule // dpr_dev

// ### verilog/dpr_link_if.sv
// link between memory controller and memory device
`timescale 1ns/100ps
interface dpr_link_if;
    logic ck;
    logic cke;
    logic rst_n;
    logic odt;
    dpr_pkg::dpr_cmd_t cmd;
    logic [2:0] ba;
    logic [12:0] addr;
    modport ctl (output ck, output cke, output rst_n, output odt, output cmd, output ba,
        output addr);
    modport dev (input ck, input cke, input rst_n, input odt, input cmd, input ba,
        input addr);
endinterface

// ### verilog/dpr_pkg.sv
// types shared by both ends of the power-down/reset link
`include "dpr_defs.svh"
package dpr_pkg;
    typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_PRE, CMD_REF, CMD_RD, CMD_WR, CMD_WRAP,
        CMD_MRS} dpr_cmd_t;
    typedef enum logic [1:0] {C_RESET, C_IDLE, C_PD} dpr_ctl_st_t;
    typedef enum logic [2:0] {D_RESET, D_IDLE, D_APD, D_PPD_FAST, D_PPD_SLOW} dpr_dev_st_t;
    typedef struct packed {
        logic ck;
        logic cke;
        logic rstn;
        logic odt;
        dpr_cmd_t cmd;
        logic [2:0] ba;
        logic [12:0] addr;
    } dpr_link_t;
    typedef struct packed {
        dpr_ctl_st_t st;
        logic [2:0] div;
        logic [4:0] rcnt;
        dpr_link_t lnk;
        logic pend;
        dpr_cmd_t pcmd;
        logic [2:0] pba;
        logic [12:0] paddr;
        logic pd_req;
        logic odt_req;
        logic ppd;
        logic slow;
        logic init_needed;
        logic [7:0] banks;
        logic [11:0] tpd;
        logic [11:0] tcke;
        logic [11:0] txp;
        logic [11:0] txpdll;
        logic [11:0] trfc;
        logic [11:0] op;
        logic [11:0] pdlen;
        logic pready;
        logic perr;
        logic [31:0] prdata;
    } dpr_ctl_t;
    typedef struct packed {
        dpr_link_t s1;
        dpr_link_t s2;
        logic ckp;
        dpr_dev_st_t st;
        logic [7:0] banks;
        logic [2:0] mr0_wr;
        logic [12:0] mr1;
        logic [1:0] rtt_wr;
        logic [3:0] dllsync;
        logic [2:0] burst;
        logic [4:0] wrapc;
        logic [2:0] wrap_ba;
        logic [12:0] refcnt;
        logic in_reset;
        logic apd;
        logic ppd;
        logic dll_on;
        logic odt_async;
        logic rtt_nom;
        logic rtt_wr_on;
        logic termination_strobe_pair_term;
    } dpr_dev_t;
endpackage
